// File: rtl/iecfg_irq.sv
// interrupt gating and the pending-clear gap timer
// assumes flags are synchronous levels from the source blocks
`timescale 1ns/1ps
`default_nettype none
module iecfg_irq #(
    parameter int gap_cycles = iecfg_pkg::gap_cycles
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // configuration
    input  wire logic [7:0] enables,
    input  wire logic       pend_cfg,
    // flags: bit0 event, bit1 gpi, bit2 overflow, bit4 logic
    input  wire logic [7:0] flags,
    input  wire logic       flag_cleared,
    // pin
    output logic            irq_n
);
    iecfg_pkg::iecfg_gap_t state;
    iecfg_pkg::iecfg_gap_t next_state;
    logic [15:0] gap;
    logic [15:0] next_gap;
    logic        any_on;
    logic        next_irq_n;

    // enabled flags ORed together
    always_comb begin
        any_on = |(flags & enables & iecfg_pkg::enables_wmask); // RL6 RL7 RL8 RL9 RL10
    end

    // a clear with others still pending either holds or blips the pin
    always_comb begin
        next_state = state;
        next_gap   = gap;
        case (state)
            iecfg_pkg::gap_idle: begin
                if (flag_cleared && any_on && pend_cfg) begin // RL4
                    next_state = iecfg_pkg::gap_low;
                    next_gap   = 16'(gap_cycles - 1);
                end
            end
            iecfg_pkg::gap_low: begin
                if (gap == 16'h0000) begin
                    next_state = iecfg_pkg::gap_idle;
                end else begin
                    next_gap = gap - 16'h0001;
                end
            end
            default: next_state = iecfg_pkg::gap_idle;
        endcase
        // with pend_cfg clear the pin simply follows any_on
        next_irq_n = !(any_on && next_state == iecfg_pkg::gap_idle); // RL3 RL10
    end

    // registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= iecfg_pkg::gap_idle;
            gap   <= 16'h0000;
            irq_n <= 1'b1;
        end else begin
            state <= next_state;
            gap   <= next_gap;
            irq_n <= next_irq_n;
        end
    end
endmodule
`default_nettype wire

// File: rtl/iecfg_osc.sv
// oscillator model and core clock-rate divider as tick pulses
// assumes sys_clk at the package rate; outputs one-cycle ticks
`timescale 1ns/1ps
`default_nettype none
module iecfg_osc (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // control
    input  wire logic       oscillator_run,
    input  wire logic [1:0] core_clock_rate_sel,
    // ticks
    output logic            osc_tick,
    output logic            core_tick
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [9:0] div;
    logic [9:0] next_div;
    logic       next_osc_tick;
    logic       next_core_tick;
    logic [9:0] ratio;

    // divide ratio picked from rate select
    always_comb begin
        case (core_clock_rate_sel)
            2'b00:   ratio = 10'(iecfg_pkg::div_50k);
            2'b01:   ratio = 10'(iecfg_pkg::div_100k);
            2'b10:   ratio = 10'(iecfg_pkg::div_200k);
            default: ratio = 10'(iecfg_pkg::div_500k);
        endcase
    end

    // counters are cleared to zero while oscillator is off, so no ticks at all
    always_comb begin
        next_cnt       = cnt;
        next_div       = div;
        next_osc_tick  = 1'b0;
        next_core_tick = 1'b0;
        if (!oscillator_run) begin // RL1
            next_cnt = 8'h00;
            next_div = 10'h000;
        end else if (cnt == 8'(2 * iecfg_pkg::osc_half - 1)) begin
            next_cnt      = 8'h00;
            next_osc_tick = 1'b1;
            if (div >= ratio - 10'h001) begin // RL2
                next_div       = 10'h000;
                next_core_tick = 1'b1;
            end else begin
                next_div = div + 10'h001;
            end
        end else begin
            next_cnt = cnt + 8'h01;
        end
    end

    // registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt       <= 8'h00;
            div       <= 10'h000;
            osc_tick  <= 1'b0;
            core_tick <= 1'b0;
        end else begin
            cnt       <= next_cnt;
            div       <= next_div;
            osc_tick  <= next_osc_tick;
            core_tick <= next_core_tick;
        end
    end
endmodule
`default_nettype wire

// File: rtl/iecfg_pkg.sv
// package for the interrupt-enable and general configuration block
// assumes a 200 MHz system clock and Avalon-MM register access
package iecfg_pkg;
    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] general_settings_ofs   = 8'h3b;
    localparam logic [7:0] irq_source_enables_ofs = 8'h3c;
    localparam logic [7:0] flag_status_ofs        = 8'h40;
    localparam logic [7:0] flag_mask_ofs          = 8'h44;
    localparam logic [7:0] flag_raw_ofs           = 8'h48;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int osc_run_bit     = 7;
    localparam int rate_hi_bit     = 6;
    localparam int rate_lo_bit     = 5;
    localparam int pend_cfg_bit    = 1;
    localparam int rst_ignore_bit  = 0;
    localparam int logic_gate_bit  = 4;
    localparam int ovf_gate_bit    = 2;
    localparam int gpi_gate_bit    = 1;
    localparam int event_gate_bit  = 0;

    // writable bits; reserved bits stay zero
    localparam logic [7:0] general_wmask = 8'he3;
    localparam logic [7:0] enables_wmask = 8'h17;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] general_rst = 8'h00;
    localparam logic [7:0] enables_rst = 8'h00;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int sys_clk_mhz  = 200;
    localparam int base_osc_khz = 1000;
    localparam int gap_time_us  = 50;
    localparam int gap_cycles   = gap_time_us * sys_clk_mhz;
    // divide ratios from 1 MHz: 50, 100, 200, 500 kHz
    localparam int div_50k  = base_osc_khz / 50;
    localparam int div_100k = base_osc_khz / 100;
    localparam int div_200k = base_osc_khz / 200;
    localparam int div_500k = base_osc_khz / 500;
    localparam int osc_half = sys_clk_mhz / 2;

    typedef enum logic [1:0] {
        gap_idle = 2'b00,
        gap_low  = 2'b01
    } iecfg_gap_t;
endpackage

// File: rtl/iecfg_top.sv
// top of the interrupt-enable and general configuration block
// assumes an Avalon-MM master on sys_clk and synchronous flag inputs
// Summary of operation
// RL1 - the 1 MHz oscillator runs only while the oscillator-run bit 7 is one.
// RL2 - bits 6 to 5 pick a core rate of 50, 100, 200 or 500 kHz from the oscillator.
// RL3 - with bit 1 low, clearing a flag while another enabled one pends keeps the pin asserted.
// RL4 - with bit 1 high, such a clear releases the pin for 50 us before it asserts again.
// RL5 - with bit 0 low a low external reset pin resets the device, with it high the pin is ignored.
// RL6 - enable bit 4 gates the logic-block flag onto the interrupt pin.
// RL7 - enable bit 2 gates the fifo overflow flag onto the interrupt pin.
// RL8 - enable bit 1 gates the input change flag onto the interrupt pin.
// RL9 - enable bit 0 gates the new-event flag onto the interrupt pin.
// RL10 - the active-low interrupt pin is the OR of all enabled flags.
// RL11 - reserved bits read as zero and should be written as zero.
`timescale 1ns/1ps
`default_nettype none
module iecfg_top #(
    parameter int gap_cycles = iecfg_pkg::gap_cycles
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // external reset pin
    input  wire logic        ext_rst_n,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // interrupt sources (levels)
    input  wire logic        new_event_flag,
    input  wire logic        input_change_flag,
    input  wire logic        fifo_overflow_flag,
    input  wire logic        logic_flag,
    input  wire logic        flag_cleared,
    // outputs
    output logic             irq_n,
    output logic             device_reset,
    output logic             osc_tick,
    output logic             core_tick,
    output logic             status_irq
);
    // ****************************************************************
    // registers
    // ****************************************************************
    logic [7:0]  general_settings;
    logic [7:0]  irq_source_enables;
    logic [7:0]  flag_status;
    logic [7:0]  flag_mask;
    logic        done;
    logic [7:0]  next_general;
    logic [7:0]  next_enables;
    logic [7:0]  next_status;
    logic [7:0]  next_mask;
    logic [31:0] next_readdata;
    logic        next_done;
    logic        next_device_reset;
    logic        next_status_irq;
    logic [7:0]  flags;
    logic [7:0]  flags_q;
    logic        wr_ok;

    // flag vector in enable-register layout
    always_comb begin
        flags = 8'h00;
        flags[iecfg_pkg::event_gate_bit] = new_event_flag;
        flags[iecfg_pkg::gpi_gate_bit]   = input_change_flag;
        flags[iecfg_pkg::ovf_gate_bit]   = fifo_overflow_flag;
        flags[iecfg_pkg::logic_gate_bit] = logic_flag;
    end

    // one wait cycle per access; a write lands only at the edge that ends the wait
    always_comb begin
        avs_waitrequest = (avs_read || avs_write) && !done;
        wr_ok           = avs_write && done && avs_byteenable[0];
    end

    // ****************************************************************
    // register file next state
    // ****************************************************************
    always_comb begin
        next_general  = general_settings;
        next_enables  = irq_source_enables;
        next_mask     = flag_mask;
        next_done     = (avs_read || avs_write) && !done;
        next_readdata = avs_readdata;
        if (wr_ok && avs_address == iecfg_pkg::general_settings_ofs) begin
            next_general = avs_writedata[7:0] & iecfg_pkg::general_wmask; // RL11
        end else if (wr_ok && avs_address == iecfg_pkg::irq_source_enables_ofs) begin
            next_enables = avs_writedata[7:0] & iecfg_pkg::enables_wmask; // RL11
        end else if (wr_ok && avs_address == iecfg_pkg::flag_mask_ofs) begin
            next_mask = avs_writedata[7:0] & iecfg_pkg::enables_wmask;
        end
        // rising flags are sticky; set wins over a write-one clear
        next_status = flag_status;
        if (wr_ok && avs_address == iecfg_pkg::flag_status_ofs) begin
            next_status = flag_status & ~avs_writedata[7:0];
        end
        next_status = next_status | (flags & ~flags_q);
        // read mux; unmapped addresses read zero
        if (avs_read && !done) begin
            if (avs_address == iecfg_pkg::general_settings_ofs) begin
                next_readdata = {24'h000000, general_settings};
            end else if (avs_address == iecfg_pkg::irq_source_enables_ofs) begin
                next_readdata = {24'h000000, irq_source_enables};
            end else if (avs_address == iecfg_pkg::flag_status_ofs) begin
                next_readdata = {24'h000000, flag_status};
            end else if (avs_address == iecfg_pkg::flag_mask_ofs) begin
                next_readdata = {24'h000000, flag_mask};
            end else if (avs_address == iecfg_pkg::flag_raw_ofs) begin
                next_readdata = {24'h000000, flags};
            end else begin
                next_readdata = 32'h00000000;
            end
        end
        next_status_irq = |(next_status & next_mask);
        // external reset honoured only while ignore bit is clear
        next_device_reset = !ext_rst_n && !general_settings[iecfg_pkg::rst_ignore_bit]; // RL5
    end

    // register update; external reset returns settings to defaults
    always_ff @(posedge sys_clk) begin
        if (!rst_n || device_reset) begin
            general_settings   <= iecfg_pkg::general_rst;
            irq_source_enables <= iecfg_pkg::enables_rst;
            flag_status        <= 8'h00;
            flag_mask          <= 8'h00;
            flags_q            <= 8'h00;
            done               <= 1'b0;
            avs_readdata       <= 32'h00000000;
            status_irq         <= 1'b0;
        end else begin
            general_settings   <= next_general;
            irq_source_enables <= next_enables;
            flag_status        <= next_status;
            flag_mask          <= next_mask;
            flags_q            <= flags;
            done               <= next_done;
            avs_readdata       <= next_readdata;
            status_irq         <= next_status_irq;
        end
    end

    // reset request kept on its own reset so it can release itself
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            device_reset <= 1'b0;
        end else begin
            device_reset <= next_device_reset;
        end
    end

    // ****************************************************************
    // submodules
    // ****************************************************************
    iecfg_osc u_osc (
        .sys_clk             (sys_clk),
        .rst_n               (rst_n),
        .oscillator_run      (general_settings[iecfg_pkg::osc_run_bit]), // RL1
        .core_clock_rate_sel (general_settings[iecfg_pkg::rate_hi_bit:iecfg_pkg::rate_lo_bit]), // RL2
        .osc_tick            (osc_tick),
        .core_tick           (core_tick)
    );

    iecfg_irq #(
        .gap_cycles (gap_cycles)
    ) u_irq (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .enables      (irq_source_enables),
        .pend_cfg     (general_settings[iecfg_pkg::pend_cfg_bit]), // RL3
        .flags        (flags),
        .flag_cleared (flag_cleared),
        .irq_n        (irq_n)
    );
endmodule
`default_nettype wire

// File: test/iecfg_props.sv
// checker for the configuration and interrupt block
// assumes it sees only the ports of iecfg_top; bound below
`timescale 1ns/1ps
`default_nettype none
module iecfg_props #(
    parameter int gap_cycles = iecfg_pkg::gap_cycles
) (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // bus and reset pin
    input wire logic        ext_rst_n,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // flags and outputs
    input wire logic        new_event_flag,
    input wire logic        input_change_flag,
    input wire logic        fifo_overflow_flag,
    input wire logic        logic_flag,
    input wire logic        flag_cleared,
    input wire logic        irq_n,
    input wire logic        device_reset,
    input wire logic        osc_tick
);
    localparam int gap_lo = gap_cycles - 10;
    localparam int gap_hi = gap_cycles + 4;
    logic [7:0] en_sh, gen_sh, next_en_sh, next_gen_sh, gated;
    logic [8:0] osc_cnt, next_osc_cnt;
    logic       seen, next_seen;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // shadow of the settings; a write lands at the edge that ends the wait
    always_comb begin
        next_en_sh   = en_sh;
        next_gen_sh  = gen_sh;
        if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
            if (avs_address == iecfg_pkg::irq_source_enables_ofs)
                next_en_sh = avs_writedata[7:0] & iecfg_pkg::enables_wmask;
            if (avs_address == iecfg_pkg::general_settings_ofs)
                next_gen_sh = avs_writedata[7:0] & iecfg_pkg::general_wmask;
        end
        if (device_reset) begin
            next_en_sh  = 8'h00;
            next_gen_sh = 8'h00;
        end
        // period only judged once a tick was seen since start
        next_seen    = gen_sh[7] && (seen || osc_tick);
        next_osc_cnt = osc_tick ? 9'h001 : osc_cnt + 9'h001;
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            en_sh   <= 8'h00;
            gen_sh  <= 8'h00;
            seen    <= 1'b0;
            osc_cnt <= 9'h000;
        end else begin
            en_sh   <= next_en_sh;
            gen_sh  <= next_gen_sh;
            seen    <= next_seen;
            osc_cnt <= next_osc_cnt;
        end
    end
    assign gated = en_sh & {3'h0, logic_flag, 1'b0, fifo_overflow_flag, input_change_flag, new_event_flag};
    // clear with another source pending and the gap mode on
    sequence s_clear_pend;
        flag_cleared && gen_sh[1] && gated != 8'h00;
    endsequence
    sequence s_gap_back;
        ##1 irq_n [*8] ##[gap_lo:gap_hi] !irq_n;
    endsequence
    a_gap_release: assert property (s_clear_pend |=> s_gap_back)
        else $error("pin gap after clear is wrong");
    a_hold_pending: assert property (!gen_sh[1] && gated != 8'h00 |=> !irq_n)
        else $error("pin not asserted for a pending source");
    a_quiet_pin: assert property (gated == 8'h00 |=> irq_n)
        else $error("pin asserted with no enabled flag");
    a_ext_reset: assert property (!ext_rst_n && !gen_sh[0] |=> device_reset)
        else $error("reset pin not obeyed");
    a_reset_ignored: assert property (ext_rst_n || gen_sh[0] |=> !device_reset)
        else $error("device reset without cause");
    a_osc_stop: assert property (!gen_sh[7] ##1 !gen_sh[7] |-> !osc_tick)
        else $error("oscillator ticks while stopped");
    a_osc_period: assert property (osc_tick && seen |-> osc_cnt == 9'h0c8)
        else $error("oscillator period wrong");
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    a_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
endmodule
bind iecfg_top iecfg_props #(.gap_cycles(gap_cycles)) u_iecfg_props (
    .sys_clk(sys_clk), .rst_n(rst_n), .ext_rst_n(ext_rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .new_event_flag(new_event_flag), .input_change_flag(input_change_flag),
    .fifo_overflow_flag(fifo_overflow_flag), .logic_flag(logic_flag), .flag_cleared(flag_cleared),
    .irq_n(irq_n), .device_reset(device_reset), .osc_tick(osc_tick)
);
`default_nettype wire

// File: test/iecfg_src.sv
// flag source model standing at the far side of the block
// assumes commands from the bench change just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module iecfg_src (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // commands: bit0 event, bit1 gpi, bit2 overflow, bit3 logic
    input  wire logic [3:0] raise,
    input  wire logic [3:0] clear,
    // toward the block
    output logic [3:0]      flags,
    output logic            flag_cleared
);
    logic [3:0] next_flags;
    logic       next_cleared;
    // flags stay up until cleared; the pulse only marks a real clear
    always_comb begin
        next_flags   = (flags | raise) & ~clear;
        next_cleared = |(flags & clear);
    end
    // registered so the flags are synchronous levels
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            flags        <= 4'h0;
            flag_cleared <= 1'b0;
        end else begin
            flags        <= next_flags;
            flag_cleared <= next_cleared;
        end
    end
endmodule
`default_nettype wire

// File: test/iecfg_top_tb.sv
// testbench for iecfg_top with the flag source model
// assumes a short gap parameter; bus calls hold until waitrequest low
`timescale 1ns/1ps
`default_nettype none
module iecfg_top_tb;
    localparam int gap = 20;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ext_rst_n = 1'b1;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [3:0]  raise = 4'h0;
    logic [3:0]  clear = 4'h0;
    logic [3:0]  flags;
    logic [31:0] avs_readdata, rdata;
    logic        avs_waitrequest, irq_n, device_reset, osc_tick, core_tick, status_irq, flag_cleared;
    logic [7:0]  gbit [4] = '{8'h01, 8'h02, 8'h04, 8'h10};
    int          errors = 0;
    int          samples_checked = 0;
    always #2.5 sys_clk = ~sys_clk;
    iecfg_top #(.gap_cycles(gap)) u_iecfg_top (
        .sys_clk(sys_clk), .rst_n(rst_n), .ext_rst_n(ext_rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .new_event_flag(flags[0]), .input_change_flag(flags[1]), .fifo_overflow_flag(flags[2]),
        .logic_flag(flags[3]), .flag_cleared(flag_cleared), .irq_n(irq_n), .device_reset(device_reset),
        .osc_tick(osc_tick), .core_tick(core_tick), .status_irq(status_irq)
    );
    iecfg_src u_iecfg_src (
        .sys_clk(sys_clk), .rst_n(rst_n), .raise(raise), .clear(clear),
        .flags(flags), .flag_cleared(flag_cleared)
    );
    // ****
    // tasks
    // ****
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one avalon access; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        avs_read      <= !wr;
        avs_write     <= wr;
        avs_address   <= a;
        avs_writedata <= {24'h0, d};
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(rdata, {24'h0, exp});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // source command, one cycle wide
    task automatic fl(input logic [3:0] r, input logic [3:0] c);
        @(posedge sys_clk);
        raise <= r;
        clear <= c;
        @(posedge sys_clk);
        raise <= 4'h0;
        clear <= 4'h0;
    endtask
    // osc ticks between two core ticks; first one skipped as the phase may be old
    task automatic rate(input logic [1:0] r, input logic [31:0] n);
        int k;
        k = 0;
        bus(1'b1, 8'h3b, {1'b1, r, 5'h00});
        repeat (2) do @(posedge sys_clk); while (core_tick !== 1'b1);
        do begin
            @(posedge sys_clk);
            k += osc_tick;
        end while (core_tick !== 1'b1);
        chk(32'(k), n);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ****
    // tests
    // ****
    initial begin
        cyc(4);
        rst_n <= 1'b1;
        rd(8'h3b, 8'h00);
        rd(8'h3c, 8'h00);
        bus(1'b1, 8'h3b, 8'hff);
        rd(8'h3b, 8'he3);
        bus(1'b1, 8'h3c, 8'hff);
        avs_byteenable <= 4'he;
        bus(1'b1, 8'h3c, 8'h00);
        avs_byteenable <= 4'hf;
        rd(8'h3c, 8'h17);
        bus(1'b1, 8'h10, 8'hff);
        rd(8'h10, 8'h00);
        bus(1'b1, 8'h3b, 8'h00);
        // each source masked alone, then alone enabled
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 8'h3c, 8'h17 & ~gbit[i]);
            fl(4'h1 << i, 4'h0);
            cyc(3);
            chk(irq_n, 1'b1);
            bus(1'b1, 8'h3c, gbit[i]);
            cyc(2);
            chk(irq_n, 1'b0);
            fl(4'h0, 4'h1 << i);
        end
        // clear one of two pending sources, steady mode
        bus(1'b1, 8'h3c, 8'h17);
        fl(4'h3, 4'h0);
        fl(4'h0, 4'h1);
        repeat (gap + 5) begin
            @(posedge sys_clk);
            chk(irq_n, 1'b0);
        end
        // same in gap mode
        bus(1'b1, 8'h3b, 8'h02);
        fl(4'h1, 4'h0);
        fl(4'h0, 4'h1);
        cyc(4);
        chk(irq_n, 1'b1);
        cyc(gap);
        chk(irq_n, 1'b0);
        fl(4'h0, 4'h2);
        // sticky status, mask and level output
        bus(1'b1, 8'h40, 8'hff);
        bus(1'b1, 8'h44, 8'h01);
        fl(4'h1, 4'h0);
        cyc(3);
        chk(status_irq, 1'b1);
        rd(8'h40, 8'h01);
        rd(8'h48, 8'h01);
        bus(1'b1, 8'h44, 8'h00);
        cyc(2);
        chk(status_irq, 1'b0);
        fl(4'h0, 4'h1);
        bus(1'b1, 8'h40, 8'h01);
        rd(8'h40, 8'h00);
        // reset pin obeyed, then ignored
        bus(1'b1, 8'h3b, 8'h00);
        ext_rst_n <= 1'b0;
        cyc(3);
        chk(device_reset, 1'b1);
        ext_rst_n <= 1'b1;
        rd(8'h3c, 8'h00);
        bus(1'b1, 8'h3b, 8'h01);
        ext_rst_n <= 1'b0;
        cyc(3);
        chk(device_reset, 1'b0);
        ext_rst_n <= 1'b1;
        rd(8'h3b, 8'h01);
        // every rate code, then oscillator stopped
        rate(2'b00, 32'd20);
        rate(2'b01, 32'd10);
        rate(2'b10, 32'd5);
        rate(2'b11, 32'd2);
        bus(1'b1, 8'h3b, 8'h00);
        begin
            int k;
            k = 0;
            repeat (400) begin
                @(posedge sys_clk);
                k += osc_tick;
            end
            chk(32'(k), 32'd0);
        end
        results;
    end
    // watchdog, well beyond the expected run length
    initial begin
        #400000;
        errors++;
        results;
    end
endmodule
`default_nettype wire
